/* core/rtsr_fifo.sv */
`timescale 1ns/1ps
module rtsr_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0]   count;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
  } rtsr_fifo_s;
  rtsr_fifo_s             st;
  rtsr_fifo_s             next_st;
  logic       [WIDTH-1:0] mem [DEPTH];
  logic                   push;
  logic                   pop;

  assign in_ready  = st.count != (AW+1)'(DEPTH);
  assign out_valid = st.count != '0;
  assign out_data  = mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr] <= in_data;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    st.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* core/rtsr_pkg.sv */
// Contract
// [RULE1] after reset the block keeps converting on its own, no command needed
// [RULE2] a new conversion starts every 0.5s (fast) or 8s (slow variant)
// [RULE3] reads return the last completed conversion, never a partial one
// [RULE4] select falling aborts any conversion; converter stays idle while select low
// [RULE5] with select low the serial port stays active and serves the last result
// [RULE6] select rising resets the serial state and starts a fresh conversion
// [RULE7] master keeps select high 320ms after a start for that conversion to finish
// [RULE8] select falling loads the result into the shift register for the frame
// [RULE9] data leaves msb first, changing on each falling serial clock edge
// [RULE10] a frame is 16 bit periods; master gives 16 clock edges
// [RULE11] bits one and zero of the frame leave the data pin undriven
// [RULE12] temperature is sign plus 12-bit magnitude, 0.0625 C per step
// [RULE13] two's complement in bits 15..3, bit 15 sign, bit 2 always zero
// [RULE14] in reset the port is inactive and the result reads as 0 C
// [RULE15] data pin is driven only while select is low
// [RULE16] no serial data input; clock edges past the frame change nothing
package rtsr_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          FAST_PERIOD_MS = 500;
  localparam int          SLOW_PERIOD_MS = 8000;
  localparam int          CONV_TIME_MS   = 250;
  localparam longint      FAST_PERIOD_CYC = longint'(FAST_PERIOD_MS) * CLK_HZ / 1000;
  localparam longint      SLOW_PERIOD_CYC = longint'(SLOW_PERIOD_MS) * CLK_HZ / 1000;
  localparam longint      CONV_TIME_CYC   = longint'(CONV_TIME_MS) * CLK_HZ / 1000;
  localparam int          FRAME_BITS    = 16;
  localparam int          TEMP_BITS     = 13;
  localparam int          HIZ_BITS      = 2;
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam int          FIFO_DEPTH    = 4;
endpackage

/* core/rtsr_readout.sv */
`timescale 1ns/1ps
module rtsr_readout #(
  parameter longint PERIOD_CYC = rtsr_pkg::FAST_PERIOD_CYC,
  parameter longint CONV_CYC   = rtsr_pkg::CONV_TIME_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sck,
  output logic             sdo,
  output logic             sdo_oe_n,
  input  wire logic [12:0] adc_code,
  output logic             conv_active,
  output logic             sample_strobe
);
  typedef enum {CONV, WAIT, IDLE} rtsr_state_e;
  typedef struct packed {
    rtsr_state_e state;
    logic [39:0] timer;
    logic [15:0] result;
    logic [15:0] shreg;
    logic [4:0]  bitcnt;
    logic        sdo;
    logic        oe_n;
    logic [1:0]  cs_sync;
    logic [1:0]  sck_sync;
    logic        cs_q;
    logic        sck_q;
  } rtsr_s;

  rtsr_s       st;
  rtsr_s       next_st;
  logic        done_pulse;
  logic        fifo_valid;
  logic [12:0] fifo_data;
  logic        fifo_ready;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_fall;

  // -------------------------------------------------
  // completed codes pass a small buffer into result
  // -------------------------------------------------
  rtsr_fifo #(.WIDTH(rtsr_pkg::TEMP_BITS), .DEPTH(rtsr_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (done_pulse),
    .in_ready  (fifo_ready),
    .in_data   (adc_code),
    .out_valid (fifo_valid),
    .out_ready (1'b1),
    .out_data  (fifo_data)
  );

  assign cs_fall  = st.cs_q && !st.cs_sync[1];
  assign cs_rise  = !st.cs_q && st.cs_sync[1];
  assign sck_fall = st.sck_q && !st.sck_sync[1];
  // a conversion only counts once its full time has elapsed
  assign done_pulse    = st.state == CONV && st.timer == 40'(CONV_CYC - 1)
                         && st.cs_sync[1] && fifo_ready; // [RULE3]
  assign conv_active   = st.state == CONV;
  assign sample_strobe = done_pulse;
  assign sdo           = st.sdo;
  assign sdo_oe_n      = st.oe_n;

  // -------------------------------------------------
  // sequencer and serial port
  // -------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.cs_sync  = {st.cs_sync[0], cs_n};
    next_st.sck_sync = {st.sck_sync[0], sck};
    next_st.cs_q     = st.cs_sync[1];
    next_st.sck_q    = st.sck_sync[1];
    next_st.timer    = st.timer + 40'd1;
    if (fifo_valid) begin
      next_st.result = {fifo_data, 3'b000}; // [RULE12] [RULE13]
    end
    unique case (st.state)
      CONV: begin
        if (st.timer >= 40'(CONV_CYC - 1)) begin
          next_st.state = WAIT;
        end
      end
      WAIT: begin
        if (st.timer >= 40'(PERIOD_CYC - 1)) begin
          next_st.state = CONV; // [RULE1] [RULE2]
          next_st.timer = '0;
        end
      end
      IDLE: begin
        next_st.timer = '0;
      end
    endcase
    if (cs_fall) begin
      next_st.state  = IDLE; // [RULE4]
      next_st.shreg  = st.result; // [RULE8]
      next_st.sdo    = st.result[15];
      next_st.oe_n   = 1'b0; // [RULE15]
      next_st.bitcnt = 5'd0;
    end else if (cs_rise) begin
      next_st.state  = CONV; // [RULE6]
      next_st.timer  = '0;
      next_st.oe_n   = 1'b1; // [RULE15]
      next_st.bitcnt = 5'd0;
      next_st.sdo    = 1'b0;
    end else if (!st.cs_q && sck_fall && st.bitcnt < 5'(rtsr_pkg::FRAME_BITS)) begin
      next_st.bitcnt = st.bitcnt + 5'd1; // [RULE5] [RULE10] [RULE16]
      next_st.shreg  = {st.shreg[14:0], 1'b0};
      next_st.sdo    = st.shreg[14]; // [RULE9]
      if (st.bitcnt + 5'd1 >= 5'(rtsr_pkg::FRAME_BITS - rtsr_pkg::HIZ_BITS)) begin
        next_st.oe_n = 1'b1; // [RULE11]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st          <= '0;
      st.state    <= CONV; // [RULE1]
      st.result   <= rtsr_pkg::RESULT_RST; // [RULE14]
      st.oe_n     <= 1'b1; // [RULE14]
      st.cs_sync  <= 2'b11;
      st.cs_q     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  a_abort_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    cs_fall |=> st.state == IDLE && !conv_active) else $error("no abort"); // [RULE4]
  a_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
    st.state == IDLE && !st.cs_q && !cs_rise |=> st.state == IDLE)
    else $error("left idle with select low"); // [RULE4]
  a_start_on_rise: assert property (@(posedge clk_sys) disable iff (rst)
    cs_rise |=> st.state == CONV && st.timer == 0 && st.bitcnt == 0)
    else $error("no restart"); // [RULE6]
  a_load_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    cs_fall |=> st.shreg == $past(st.result) && !sdo_oe_n)
    else $error("frame not loaded"); // [RULE8]
  a_drive_when_sel: assert property (@(posedge clk_sys) disable iff (rst)
    !sdo_oe_n |-> !st.cs_q || cs_rise) else $error("drive with select high"); // [RULE15]
  a_tail_hiz: assert property (@(posedge clk_sys) disable iff (rst)
    st.bitcnt >= 5'd14 |-> sdo_oe_n) else $error("tail bits driven"); // [RULE11]
  a_bit2_zero: assert property (@(posedge clk_sys) disable iff (rst)
    st.result[2:0] == 3'b000) else $error("low bits not zero"); // [RULE13]
  // the pin itself, not only the stored word, must show zero in the bit two slot
  a_bit2_pin: assert property (@(posedge clk_sys) disable iff (rst) // [RULE13]
    !sdo_oe_n && st.bitcnt == 5'd13 |-> !sdo) else $error("bit two driven high");
  a_shift_step: assert property (@(posedge clk_sys) disable iff (rst)
    !st.cs_q && sck_fall && !cs_rise && !cs_fall && st.bitcnt < 5'd16
    |=> st.bitcnt == $past(st.bitcnt) + 5'd1 && sdo == $past(st.shreg[14]))
    else $error("bad shift"); // [RULE9]
  a_frame_limit: assert property (@(posedge clk_sys) disable iff (rst)
    st.bitcnt <= 5'd16) else $error("frame overrun"); // [RULE16]
  a_result_update: assert property (@(posedge clk_sys) disable iff (rst)
    done_pulse |=> ##1 st.result[15:3] == $past(adc_code, 2))
    else $error("result not updated"); // [RULE3]
endmodule

/* verification/rtsr_master.sv */
`timescale 1ns/1ps
module rtsr_master (
  output logic      cs_n,
  output logic      sck,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  logic line;
  // a released pin shows the inverse, so a stale level never passes
  assign line = sdo_oe_n ? ~sdo : sdo;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
  end
  // ----------------------------------------
  // one read frame, serial clock idle low
  // ----------------------------------------
  task automatic frame(input int edges, output logic [15:0] word, output logic [15:0] drv);
    word = 16'h0000;
    drv  = 16'h0000;
    cs_n <= 1'b0;
    #80;
    for (int i = 0; i < edges; i++) begin
      sck <= 1'b1;
      #40;
      // sampled late in the bit, well after the falling-edge update
      if (i < 16) begin
        word[15-i] = line;
        drv[15-i]  = ~sdo_oe_n;
      end
      sck <= 1'b0;
      #40;
    end
    cs_n <= 1'b1;
    #40;
  endtask
endmodule

/* verification/test_remote_temp_spi_readout.sv */
`timescale 1ns/1ps
module test_remote_temp_spi_readout;
  localparam longint PER = 200;
  localparam longint CNV = 50;
  logic        clk_sys;
  logic        rst;
  logic        cs_n;
  logic        sck;
  logic        sdo;
  logic        sdo_oe_n;
  logic        conv_active;
  logic        sample_strobe;
  logic [12:0] adc_code;
  logic [15:0] word;
  logic [15:0] drv;
  int          err_count;
  int          checks;
  int          n;
  logic [12:0] codes [3] = '{13'h0190, 13'h0001, 13'h1e70};
  rtsr_readout #(.PERIOD_CYC(PER), .CONV_CYC(CNV)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .cs_n(cs_n), .sck(sck), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .adc_code(adc_code),
    .conv_active(conv_active), .sample_strobe(sample_strobe));
  rtsr_master u_master (.cs_n(cs_n), .sck(sck), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d of %0d compares", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_strobe(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sample_strobe !== 1'b1 && n < lim);
    if (sample_strobe !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED t=%0t no conversion end", $time);
      results();
    end
  endtask
  task automatic read(input int edges, input logic [12:0] temp);
    u_master.frame(edges, word, drv);
    check(word & 16'hfffc, {temp, 3'b000}, "frame data");
    check(drv, 16'hfffc, "drive window");
    repeat (8) @(posedge clk_sys);
    #1;
    check(16'(sdo_oe_n), 16'h0001, "released");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    repeat (5) @(posedge clk_sys);
    #1;
    check(16'(sdo_oe_n), 16'h0001, "idle in reset");
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(conv_active), 16'h0001, "converting after reset");
    read(16, 13'h0000);
  endtask
  task automatic t_free;
    wait_strobe(400);
    wait_strobe(400);
    check(16'(n), 16'(PER), "restart period");
    for (int k = 0; k < 3; k++) begin
      adc_code <= codes[k];
      wait_strobe(400);
      repeat (3) @(posedge clk_sys);
      read(16, codes[k]);
    end
  endtask
  // a short select pulse must abort, and a cut frame must not skew the next
  task automatic t_abort;
    adc_code <= 13'h0abc;
    fork
      u_master.frame(5, word, drv);
      begin
        #305;
        check(16'(conv_active), 16'h0000, "stopped while selected");
      end
    join
    check(word & 16'hf800, {13'h1e70, 3'b000} & 16'hf800, "cut frame data");
    check(drv, 16'hf800, "cut frame drive");
    // a cut frame still drives, so only the select rise can release the pin
    repeat (8) @(posedge clk_sys);
    #1;
    check(16'(sdo_oe_n), 16'h0001, "cut frame released");
    read(16, 13'h1e70);
    wait_strobe(400);
    repeat (3) @(posedge clk_sys);
    read(18, 13'h0abc);
  endtask
  initial begin
    rst       = 1'b1;
    adc_code  = 13'h0000;
    err_count = 0;
    checks    = 0;
    t_reset();
    t_free();
    t_abort();
    results();
  end
endmodule
